// [at2_pkg.sv]
package at2_pkg;
  typedef logic [7:0] at2_byte_type;
  // complete state of the timer control block
  typedef struct packed {
    at2_byte_type [4:0] tmp;
    at2_byte_type [4:0] work;
    logic [2:0]         mask;
    logic [2:0]         flags;
    logic [2:0]         irq;
    logic [4:0]         busy;
    logic               extClk;
    logic               asyncSel;
    logic               syncHold;
    logic               pscRst;
    logic               down;
    logic               block;
    logic               waveA;
    logic               waveB;
    logic               oscPrev;
    logic               waitReq;
    logic               xtalEn;
    logic               extBufEn;
    at2_byte_type       rdData;
  } at2_state_type;
  // prescaler state
  typedef struct packed {
    logic [9:0] cnt;
  } at2_psc_type;
endpackage

// [at2_prescaler.sv]
`timescale 1ns/10ps
`include "at2_regs.svh"
module at2_prescaler
  import at2_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       srcTick,
  input  wire logic       pscClear,
  input  wire logic [2:0] clkSel,
  output logic            cntEn
);
  at2_psc_type st_r;
  at2_psc_type st_nxt;

  // ---------------------------------------------------------------
  // divider chain on the source tick
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    if (pscClear)
      st_nxt.cnt = '0;
    else if (srcTick)
      st_nxt.cnt = st_r.cnt + 1'b1;
  end

  // tap select, stopped while held in reset
  always_comb
  begin
    case (clkSel)
      `AT2_CS_D1:    cntEn = srcTick;
      `AT2_CS_D8:    cntEn = srcTick & (&st_r.cnt[`AT2_TAP_D8:0]);
      `AT2_CS_D32:   cntEn = srcTick & (&st_r.cnt[`AT2_TAP_D32:0]);
      `AT2_CS_D64:   cntEn = srcTick & (&st_r.cnt[`AT2_TAP_D64:0]);
      `AT2_CS_D128:  cntEn = srcTick & (&st_r.cnt[`AT2_TAP_D128:0]);
      `AT2_CS_D256:  cntEn = srcTick & (&st_r.cnt[`AT2_TAP_D256:0]);
      `AT2_CS_D1024: cntEn = srcTick & (&st_r.cnt[`AT2_TAP_D1024:0]);
      default:       cntEn = 1'b0;
    endcase
    if (pscClear)
      cntEn = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule

// [at2_regs.svh]
`ifndef AT2_REGS_SVH
`define AT2_REGS_SVH
// -----------------------------------------------------------------
// register word indices on the avalon address
// -----------------------------------------------------------------
`define AT2_A_CTLA 4'h0
`define AT2_A_CTLB 4'h1
`define AT2_A_CNT 4'h2
`define AT2_A_OCRA 4'h3
`define AT2_A_OCRB 4'h4
`define AT2_A_MASK 4'h5
`define AT2_A_FLAGS 4'h6
`define AT2_A_STAT 4'h7
`define AT2_A_GTC 4'h8
// -----------------------------------------------------------------
// slot indices, equal to the update-busy bit positions
// -----------------------------------------------------------------
`define AT2_IX_CTLB 0
`define AT2_IX_CTLA 1
`define AT2_IX_OCRB 2
`define AT2_IX_OCRA 3
`define AT2_IX_CNT 4
`define AT2_NSLOT 5
// -----------------------------------------------------------------
// bit positions and fields
// -----------------------------------------------------------------
`define AT2_B_FOCA 7
`define AT2_B_FOCB 6
`define AT2_B_WGM2 3
`define AT2_B_EXT_CLOCK_ENABLE 6
`define AT2_B_ASEL 5
`define AT2_B_TSM 7
`define AT2_B_PSR 1
`define AT2_B_TOV 0
`define AT2_B_OCFA 1
`define AT2_TAP_D8 2
`define AT2_TAP_D32 4
`define AT2_TAP_D64 5
`define AT2_TAP_D128 6
`define AT2_TAP_D256 7
`define AT2_TAP_D1024 9
`define AT2_F_COMA 7:6
`define AT2_F_COMB 5:4
`define AT2_F_WGML 1:0
`define AT2_F_CS 2:0
`define AT2_F_IRQ 2:0
`define AT2_CTLA_MASK 8'hf3
`define AT2_CTLB_MASK 8'h0f
// -----------------------------------------------------------------
// clock select, modes, counter limits
// -----------------------------------------------------------------
`define AT2_CS_STOP 3'h0
`define AT2_CS_D1 3'h1
`define AT2_CS_D8 3'h2
`define AT2_CS_D32 3'h3
`define AT2_CS_D64 3'h4
`define AT2_CS_D128 3'h5
`define AT2_CS_D256 3'h6
`define AT2_CS_D1024 3'h7
`define AT2_WGM_CTC 3'h2
`define AT2_WGM_FPWM_A 3'h7
`define AT2_COM_TOG 2'h1
`define AT2_COM_CLR 2'h2
`define AT2_COM_SET 2'h3
`define AT2_MAX 8'hff
`define AT2_BOTTOM 8'h00
`endif

// [at2_timer.sv]
// Function
// - force strobe acts as match in non-pwm
// - force sets no flag, clears nothing, reads zero
// - control b bits 5:4 read zero
// - clock select stops, passes or prescales clock
// - counter read/write; write blocks next match
// - compare registers matched against counter on each count enable
// - irq needs enable, global bit and flag
// - compare flags set on match, cleared w1c/vector
// - overflow flag; phase-correct sets at bottom
// - status bit 7 reads zero
// - external clock buffer versus crystal enable
// - async select picks timer clock source
// - async writes set update-busy flags
// - counter reads live; control and compare registers read temporaries
// - prescaler reset self-clears, waits, or holds
// - three mode bits pick counting mode
`timescale 1ns/10ps
`include "at2_regs.svh"
module at2_timer
  import at2_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        timerOscPin,
  input  wire logic        globalIrqEnable,
  input  wire logic [2:0]  vectorAck,
  output logic      [2:0]  irqReq,
  output logic             waveOutA,
  output logic             waveOutB,
  output logic             xtalOscEnable,
  output logic             extClkBufEnable
);
  at2_state_type st_r;
  at2_state_type s;
  logic          srcTick;
  logic          cntEn;
  logic          wrAcc;
  logic [7:0]    wd;
  logic [2:0]    wgm;
  logic          forceA;
  logic          forceB;
  logic          mA;
  logic          mB;
  logic          tov;
  logic          bottom;
  logic [7:0]    cnt;
  logic [7:0]    top;
  logic          phase;
  logic [2:0]    clr;

  // ---------------------------------------------------------------
  // output waveform update for one channel
  // ---------------------------------------------------------------
  function automatic logic waveNext(input logic cur, input logic [1:0] com,
    input logic [2:0] mode, input logic dn, input logic hit, input logic bot,
    input logic canTog);
    logic v;
    v = cur;
    if (!mode[0])
    begin
      if (hit)
        v = (com == `AT2_COM_TOG) ? ~cur : (com == `AT2_COM_CLR) ? 1'b0 :
            (com == `AT2_COM_SET) ? 1'b1 : cur;
    end
    else if (hit && com == `AT2_COM_TOG)
      v = canTog ? ~cur : cur;
    else if (mode[1])
    begin
      if (hit && com[1])
        v = com[0];
      else if (bot && com[1])
        v = ~com[0];
    end
    else if (hit && com[1])
      v = dn ^ com[0];
    return v;
  endfunction

  // ---------------------------------------------------------------
  // clock source and decode
  // ---------------------------------------------------------------
  // timer clock from the oscillator pin edge or every cycle
  assign srcTick = st_r.asyncSel ? (timerOscPin & ~st_r.oscPrev) : 1'b1;
  assign wrAcc = avs_write & ~st_r.waitReq;
  assign wd = avs_writedata[7:0];
  assign cnt = st_r.work[`AT2_IX_CNT];
  assign wgm = {st_r.work[`AT2_IX_CTLB][`AT2_B_WGM2], st_r.work[`AT2_IX_CTLA][`AT2_F_WGML]};
  assign phase = wgm[0] & ~wgm[1];
  // compare a is top in ctc and in modes 5 and 7
  assign top = (wgm == `AT2_WGM_CTC || (wgm[2] && wgm[0])) ?
               st_r.work[`AT2_IX_OCRA] : `AT2_MAX;
  // strobes act only in non-pwm modes
  assign forceA = wrAcc && avs_address == `AT2_A_CTLB && wd[`AT2_B_FOCA] && !wgm[0];
  assign forceB = wrAcc && avs_address == `AT2_A_CTLB && wd[`AT2_B_FOCB] && !wgm[0];
  assign mA = cntEn && !st_r.block && cnt == st_r.work[`AT2_IX_OCRA];
  assign mB = cntEn && !st_r.block && cnt == st_r.work[`AT2_IX_OCRB];
  assign clr = vectorAck | ((wrAcc && avs_address == `AT2_A_FLAGS) ? wd[`AT2_F_IRQ] : 3'h0);

  // prescaler and tap select
  at2_prescaler u_psc (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .srcTick  (srcTick),
    .pscClear (st_r.pscRst),
    .clkSel   (st_r.work[`AT2_IX_CTLB][`AT2_F_CS]),
    .cntEn    (cntEn)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s = st_r;
    tov = 1'b0;
    bottom = 1'b0;
    s.oscPrev = timerOscPin;
    // counting sequence per mode
    if (cntEn)
    begin
      s.block = 1'b0;
      if (phase)
      begin
        if (!st_r.down)
        begin
          s.down = (cnt == top);
          s.work[`AT2_IX_CNT] = (cnt == top) ? cnt - 1'b1 : cnt + 1'b1;
        end
        else if (cnt == `AT2_BOTTOM)
        begin
          s.down = 1'b0;
          s.work[`AT2_IX_CNT] = cnt + 1'b1;
          tov = 1'b1;
        end
        else
          s.work[`AT2_IX_CNT] = cnt - 1'b1;
      end
      else
      begin
        s.down = 1'b0;
        bottom = (cnt == top);
        s.work[`AT2_IX_CNT] = bottom ? `AT2_BOTTOM : cnt + 1'b1;
        tov = (wgm == `AT2_WGM_FPWM_A) ? bottom : (cnt == `AT2_MAX);
      end
    end
    // flags: a set in the same cycle beats a clear
    s.flags = (st_r.flags & ~clr) | {mB, mA, tov};
    s.irq = st_r.flags & st_r.mask & {3{globalIrqEnable}};
    s.waveA = waveNext(st_r.waveA, st_r.work[`AT2_IX_CTLA][`AT2_F_COMA], wgm, st_r.down,
                       mA | forceA, bottom, wgm[2]);
    s.waveB = waveNext(st_r.waveB, st_r.work[`AT2_IX_CTLA][`AT2_F_COMB], wgm, st_r.down,
                       mB | forceB, bottom, 1'b0);
    // move temporaries into working registers on the timer clock
    if (srcTick)
    begin
      for (int i = 0; i < `AT2_NSLOT; i++)
      begin
        if (st_r.busy[i])
        begin
          s.work[i] = st_r.tmp[i];
          s.busy[i] = 1'b0;
        end
      end
      if (st_r.busy[`AT2_IX_CNT])
        s.block = 1'b1;
    end
    // prescaler reset release
    if (st_r.pscRst && !st_r.syncHold && (!st_r.asyncSel || srcTick))
      s.pscRst = 1'b0;
    // register writes
    if (wrAcc)
    begin
      case (avs_address)
        `AT2_A_CTLA, `AT2_A_CTLB, `AT2_A_CNT, `AT2_A_OCRA, `AT2_A_OCRB:
        begin
          for (int i = 0; i < `AT2_NSLOT; i++)
          begin
            if ((avs_address == `AT2_A_CTLA && i == `AT2_IX_CTLA) ||
                (avs_address == `AT2_A_CTLB && i == `AT2_IX_CTLB) ||
                (avs_address == `AT2_A_CNT && i == `AT2_IX_CNT) ||
                (avs_address == `AT2_A_OCRA && i == `AT2_IX_OCRA) ||
                (avs_address == `AT2_A_OCRB && i == `AT2_IX_OCRB))
            begin
              // strobe and reserved bits are never stored
              s.tmp[i] = wd & ((i == `AT2_IX_CTLB) ? `AT2_CTLB_MASK :
                         (i == `AT2_IX_CTLA) ? `AT2_CTLA_MASK : `AT2_MAX);
              if (st_r.asyncSel)
                s.busy[i] = 1'b1;
              else
                s.work[i] = s.tmp[i];
              if (!st_r.asyncSel && i == `AT2_IX_CNT)
                s.block = 1'b1;
            end
          end
        end
        `AT2_A_MASK:
          s.mask = wd[`AT2_F_IRQ];
        `AT2_A_STAT:
        begin
          s.extClk = wd[`AT2_B_EXT_CLOCK_ENABLE];
          s.asyncSel = wd[`AT2_B_ASEL];
        end
        `AT2_A_GTC:
        begin
          s.syncHold = wd[`AT2_B_TSM];
          if (wd[`AT2_B_PSR])
            s.pscRst = 1'b1;
        end
        default:
          s.mask = st_r.mask;
      endcase
    end
    s.xtalEn = ~s.extClk;
    s.extBufEn = s.extClk & s.asyncSel;
    // read data captured while waitrequest is still high
    s.rdData = '0;
    if (avs_read && st_r.waitReq)
    begin
      case (avs_address)
        `AT2_A_CTLA:  s.rdData = st_r.tmp[`AT2_IX_CTLA];
        `AT2_A_CTLB:  s.rdData = st_r.tmp[`AT2_IX_CTLB];
        `AT2_A_CNT:   s.rdData = st_r.work[`AT2_IX_CNT];
        `AT2_A_OCRA:  s.rdData = st_r.tmp[`AT2_IX_OCRA];
        `AT2_A_OCRB:  s.rdData = st_r.tmp[`AT2_IX_OCRB];
        `AT2_A_MASK:  s.rdData = {5'h00, st_r.mask};
        `AT2_A_FLAGS: s.rdData = {5'h00, st_r.flags};
        `AT2_A_STAT:  s.rdData = {1'b0, st_r.extClk, st_r.asyncSel, st_r.busy};
        `AT2_A_GTC:   s.rdData = {st_r.syncHold, 5'h00, st_r.pscRst, 1'b0};
        default:      s.rdData = '0;
      endcase
    end
    // one wait cycle, then a single-cycle acknowledge
    s.waitReq = ~((avs_read | avs_write) & st_r.waitReq);
  end

  // state register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      st_r <= '0;
      st_r.waitReq <= 1'b1;
      st_r.xtalEn <= 1'b1;
    end
    else
      st_r <= s;
  end

  // outputs straight from the state register
  assign avs_readdata = {24'h000000, st_r.rdData};
  assign avs_waitrequest = st_r.waitReq;
  assign irqReq = st_r.irq;
  assign waveOutA = st_r.waveA;
  assign waveOutB = st_r.waveB;
  assign xtalOscEnable = st_r.xtalEn;
  assign extClkBufEnable = st_r.extBufEn;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_ctlb_rsvd;
    avs_read && st_r.waitReq && avs_address == `AT2_A_CTLB |=> avs_readdata[7:4] == 4'h0;
  endproperty
  a_ctlb_rsvd: assert property (p_ctlb_rsvd) else $error("control b upper bits not zero");

  property p_stat_rsvd;
    avs_read && st_r.waitReq && avs_address == `AT2_A_STAT |=> !avs_readdata[7];
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd) else $error("status bit 7 not zero");

  property p_force_noflag;
    (forceA || forceB) && !cntEn |=> (st_r.flags & ~$past(st_r.flags)) == 3'h0;
  endproperty
  a_force_noflag: assert property (p_force_noflag) else $error("force set a flag");

  property p_force_tog;
    forceA && st_r.work[`AT2_IX_CTLA][`AT2_F_COMA] == `AT2_COM_TOG && !mA
      |=> waveOutA != $past(waveOutA);
  endproperty
  a_force_tog: assert property (p_force_tog) else $error("force did not toggle");

  property p_busy_set;
    wrAcc && st_r.asyncSel && avs_address == `AT2_A_OCRA |=> st_r.busy[`AT2_IX_OCRA];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set");

  property p_xfer;
    st_r.busy[`AT2_IX_OCRA] && srcTick && !wrAcc
      |=> !st_r.busy[`AT2_IX_OCRA] && st_r.work[`AT2_IX_OCRA] == st_r.tmp[`AT2_IX_OCRA];
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer missing");

  property p_irq;
    st_r.flags[`AT2_B_OCFA] && st_r.mask[`AT2_B_OCFA] && globalIrqEnable
      ##1 st_r.flags[`AT2_B_OCFA]
      |-> irqReq[`AT2_B_OCFA];
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_w1c;
    wrAcc && avs_address == `AT2_A_FLAGS && wd[`AT2_B_TOV] && !cntEn
      |=> !st_r.flags[`AT2_B_TOV];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");

  property p_psr_sync;
    wrAcc && avs_address == `AT2_A_GTC && wd[`AT2_B_PSR] && !wd[`AT2_B_TSM] &&
      !st_r.asyncSel && !st_r.pscRst |=> st_r.pscRst ##1 !st_r.pscRst;
  endproperty
  a_psr_sync: assert property (p_psr_sync) else $error("prescaler reset stuck");

  property p_stop;
    st_r.work[`AT2_IX_CTLB][`AT2_F_CS] == `AT2_CS_STOP |-> !cntEn;
  endproperty
  a_stop: assert property (p_stop) else $error("counter runs while stopped");

  property p_phase_tov;
    cntEn && phase && st_r.down && cnt == `AT2_BOTTOM |=> st_r.flags[`AT2_B_TOV];
  endproperty
  a_phase_tov: assert property (p_phase_tov) else $error("no overflow at bottom turn");

  property p_force_nocnt;
    (forceA || forceB) && !cntEn && !st_r.busy[`AT2_IX_CNT] |=> cnt == $past(cnt);
  endproperty
  a_force_nocnt: assert property (p_force_nocnt) else $error("force moved counter");

  property p_cnt_block;
    wrAcc && avs_address == `AT2_A_CNT && !st_r.asyncSel |=> !mA && !mB;
  endproperty
  a_cnt_block: assert property (p_cnt_block) else $error("match after counter write");

  property p_clk_pins;
    xtalOscEnable == !st_r.extClk && extClkBufEnable == (st_r.extClk && st_r.asyncSel);
  endproperty
  a_clk_pins: assert property (p_clk_pins) else $error("clock pin enables wrong");

  c_force: cover property (forceA);
  c_xfer: cover property (st_r.busy[`AT2_IX_CNT] ##[1:50] !st_r.busy[`AT2_IX_CNT]);
  c_ovf: cover property (tov && phase);
endmodule

// [tb_at2_timer.sv]
`timescale 1ns/10ps
`include "at2_regs.svh"
module tb_at2_timer;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        timerOscPin = 1'b0;
  logic        globalIrqEnable = 1'b0;
  logic [2:0]  vectorAck = 3'h0;
  logic [2:0]  irqReq;
  logic        waveOutA;
  logic        waveOutB;
  logic        xtalOscEnable;
  logic        extClkBufEnable;
  int          errorCnt = 0;
  int          totalChecks = 0;

  at2_timer i_dut (
    .sys_clk         (sys_clk),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .timerOscPin     (timerOscPin),
    .globalIrqEnable (globalIrqEnable),
    .vectorAck       (vectorAck),
    .irqReq          (irqReq),
    .waveOutA        (waveOutA),
    .waveOutB        (waveOutB),
    .xtalOscEnable   (xtalOscEnable),
    .extClkBufEnable (extClkBufEnable)
  );

  // 100 mhz clock
  always #5 sys_clk = ~sys_clk;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic summarize;
    $display("checks %0d errors %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    totalChecks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is sampled low
  task automatic busXfer(input logic wr, input logic [3:0] a, input logic [7:0] d,
                         output logic [7:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      errorCnt++;
      $display("BAD %0t bus timeout", $time);
      summarize();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    busXfer(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp, input string what);
    logic [7:0] q;
    busXfer(1'b0, a, 8'h00, q);
    chk(q, exp, what);
  endtask

  // poll the flag register until bit b is set, bounded
  task automatic waitFlag(input int b);
    logic [7:0] q;
    int n;
    n = 0;
    do
    begin
      busXfer(1'b0, `AT2_A_FLAGS, 8'h00, q);
      n++;
    end
    while (q[b] !== 1'b1 && n < 300);
    chk({7'h0, q[b]}, 8'h01, "flag not set");
  endtask

  // one rising edge on the oscillator pin, slow against sys_clk
  task automatic oscTick;
    repeat (3) @(posedge sys_clk);
    timerOscPin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    timerOscPin <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic tReset;
    for (int a = 0; a < 10; a++)
      rdChk(a[3:0], 8'h00, "reset or unmapped read");
    chk({7'h0, xtalOscEnable}, 8'h01, "crystal off after reset");
    chk({7'h0, extClkBufEnable}, 8'h00, "ext buffer on after reset");
  endtask

  task automatic tCtlB;
    wr(`AT2_A_CTLB, 8'hff);
    rdChk(`AT2_A_CTLB, 8'h0f, "strobes or reserved bits read");
    wr(`AT2_A_CTLB, 8'h00);
  endtask

  task automatic tForce;
    wr(`AT2_A_OCRA, 8'h80);
    wr(`AT2_A_CTLA, 8'h40);
    wr(`AT2_A_CTLB, 8'h80);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, waveOutA}, 8'h01, "force a no toggle");
    rdChk(`AT2_A_FLAGS, 8'h00, "force raised a flag");
    wr(`AT2_A_CTLA, 8'h70);
    wr(`AT2_A_CTLB, 8'h40);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, waveOutB}, 8'h01, "force b no set");
    wr(`AT2_A_CTLA, 8'h83);
    wr(`AT2_A_CTLB, 8'h80);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, waveOutA}, 8'h01, "force acted in pwm");
    wr(`AT2_A_CTLB, 8'h00);
    wr(`AT2_A_CTLA, 8'h00);
  endtask

  task automatic tMatch;
    wr(`AT2_A_OCRA, 8'h10);
    wr(`AT2_A_CNT, 8'h08);
    rdChk(`AT2_A_CNT, 8'h08, "counter readback");
    wr(`AT2_A_MASK, 8'h02);
    rdChk(`AT2_A_MASK, 8'h02, "mask readback");
    globalIrqEnable <= 1'b1;
    wr(`AT2_A_CTLB, 8'h01);
    waitFlag(1);
    wr(`AT2_A_CTLB, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk({5'h0, irqReq}, 8'h02, "compare a irq");
    globalIrqEnable <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({5'h0, irqReq}, 8'h00, "irq without global bit");
    vectorAck <= 3'h2;
    @(posedge sys_clk);
    vectorAck <= 3'h0;
    rdChk(`AT2_A_FLAGS, 8'h00, "vector did not clear");
    wr(`AT2_A_CNT, 8'hfd);
    wr(`AT2_A_CTLB, 8'h01);
    waitFlag(0);
    wr(`AT2_A_CTLB, 8'h00);
    wr(`AT2_A_FLAGS, 8'h07);
    rdChk(`AT2_A_FLAGS, 8'h00, "write one did not clear");
    wr(`AT2_A_MASK, 8'h00);
  endtask

  // each divider: counts after 4*div cycles land near 4
  task automatic tPsc;
    int div[7] = '{1, 8, 32, 64, 128, 256, 1024};
    logic [7:0] q;
    logic [7:0] hi;
    logic ok;
    for (int i = 0; i < 7; i++)
    begin
      wr(`AT2_A_GTC, 8'h02);
      rdChk(`AT2_A_GTC, 8'h00, "prescaler reset stuck");
      wr(`AT2_A_CNT, 8'h00);
      wr(`AT2_A_CTLB, 8'(i + 1));
      repeat (4 * div[i]) @(posedge sys_clk);
      wr(`AT2_A_CTLB, 8'h00);
      busXfer(1'b0, `AT2_A_CNT, 8'h00, q);
      hi = (i == 0) ? 8'h0a : 8'h05;
      ok = (q >= 8'h03) && (q <= hi);
      totalChecks++;
      if (ok !== 1'b1)
      begin
        errorCnt++;
        $display("BAD %0t divider %0d count %h", $time, div[i], q);
      end
      repeat (20) @(posedge sys_clk);
      rdChk(`AT2_A_CNT, q, "count moved while stopped");
    end
  endtask

  task automatic tCtc;
    logic [7:0] q;
    logic ok;
    wr(`AT2_A_OCRA, 8'h05);
    wr(`AT2_A_CNT, 8'h00);
    wr(`AT2_A_CTLA, 8'h02);
    wr(`AT2_A_CTLB, 8'h01);
    repeat (40) @(posedge sys_clk);
    wr(`AT2_A_CTLB, 8'h00);
    busXfer(1'b0, `AT2_A_CNT, 8'h00, q);
    ok = (q <= 8'h05);
    chk({7'h0, ok}, 8'h01, "clear on match exceeded top");
    wr(`AT2_A_CTLA, 8'h00);
    wr(`AT2_A_FLAGS, 8'h07);
  endtask

  // phase-correct turn at bottom, then fast pwm with compare a as top
  task automatic tPwm;
    logic [7:0] q;
    wr(`AT2_A_CNT, 8'hfc);
    wr(`AT2_A_CTLA, 8'h81);
    wr(`AT2_A_CTLB, 8'h01);
    repeat (20) @(posedge sys_clk);
    rdChk(`AT2_A_FLAGS, 8'h00, "overflow set at max in phase mode");
    waitFlag(0);
    chk({7'h0, waveOutA}, 8'h01, "down-count match did not set");
    wr(`AT2_A_CTLB, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk({7'h0, waveOutA}, 8'h00, "up-count match did not clear");
    wr(`AT2_A_CTLA, 8'h03);
    wr(`AT2_A_FLAGS, 8'h07);
    wr(`AT2_A_CNT, 8'h00);
    wr(`AT2_A_CTLB, 8'h09);
    repeat (20) @(posedge sys_clk);
    wr(`AT2_A_CTLB, 8'h00);
    busXfer(1'b0, `AT2_A_CNT, 8'h00, q);
    chk({7'h0, (q <= 8'h05)}, 8'h01, "fast pwm exceeded top");
    rdChk(`AT2_A_FLAGS, 8'h07, "fast pwm overflow not at top");
    wr(`AT2_A_CTLA, 8'h00);
    wr(`AT2_A_FLAGS, 8'h07);
  endtask

  task automatic tAsync;
    wr(`AT2_A_STAT, 8'h40);
    wr(`AT2_A_STAT, 8'h60);
    repeat (2) @(posedge sys_clk);
    chk({6'h0, xtalOscEnable, extClkBufEnable}, 8'h01, "clock pin mode");
    wr(`AT2_A_OCRA, 8'h33);
    rdChk(`AT2_A_STAT, 8'h68, "busy not set");
    rdChk(`AT2_A_OCRA, 8'h33, "temporary readback");
    oscTick();
    rdChk(`AT2_A_STAT, 8'h60, "busy not released");
    wr(`AT2_A_GTC, 8'h02);
    rdChk(`AT2_A_GTC, 8'h02, "async prescaler reset cleared early");
    oscTick();
    rdChk(`AT2_A_GTC, 8'h00, "async prescaler reset stuck");
    wr(`AT2_A_STAT, 8'he0);
    rdChk(`AT2_A_STAT, 8'h60, "status bit 7 read");
    wr(`AT2_A_STAT, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk({6'h0, xtalOscEnable, extClkBufEnable}, 8'h02, "sync clock mode");
    wr(`AT2_A_GTC, 8'h82);
    repeat (3) @(posedge sys_clk);
    rdChk(`AT2_A_GTC, 8'h82, "reset cleared under hold");
  endtask

  // -----------------------------------------------------------------
  // main sequence and watchdog
  // -----------------------------------------------------------------
  initial
  begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    tReset();
    tCtlB();
    tForce();
    tMatch();
    tPsc();
    tCtc();
    tPwm();
    tAsync();
    summarize();
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    errorCnt++;
    $display("BAD %0t run timeout", $time);
    summarize();
  end
endmodule
